// >>> rtl/smx_mixer.sv
// Signal mixer output and control logic with its Wishbone register slave.
//
// Chosen here: the register offsets and the Wishbone register port.
`default_nettype none
// Behaviour
// R1: Upper carrier release bit detaches the selected upper carrier source from its pin.
// R2: Lower carrier release bit detaches the selected lower carrier source from its pin.
// R3: The software keying value can be chosen as the keying source.
// R4: Keying source release bit detaches the selected keying source from its pin.
// R5: Output invert bit inverts the mixed signal before the pin.
// R6: Slew limit bit resets to one; clearing it removes pad slew limiting.
// R7: Mixer ignores Sleep and keeps operating unchanged.
// R8: In Sleep output continues while the chosen sources keep running.
// R9: Any reset disables the mixer and restores every register default.
// R10: Firmware configures everything after reset before enabling the pin drive.
// R11: Pin drive bit, reset zero, gates the mixed signal onto the pin.
// R12: Read-only status bit shows the mixed value, zero after reset, unwritable.
// R13: Output uses upper carrier while keying is high, lower while low.
// R14: Clearing modulator_on grounds carriers, picks soft keying, keeps stored selections.
// R15: With pin drive off the pin stays low while mixing continues.
module smx_mixer
  import smx_pkg::*;
#(
  parameter int NK = 10, // Keying sources besides the software value.
  parameter int NC = 7 // Carrier sources besides ground.
) (
  input wire logic clk, // System clock, 40 MHz.
  input wire logic resetn, // Asynchronous active-low reset.
  input wire logic wb_cyc, // Wishbone cycle.
  input wire logic wb_stb, // Wishbone strobe.
  input wire logic wb_we, // Wishbone write enable.
  input wire logic [smx_pkg::ADR_W-1:0] wb_adr, // Wishbone byte address.
  input wire logic [3:0] wb_sel, // Wishbone byte enables.
  input wire logic [smx_pkg::DAT_W-1:0] wb_dat_w, // Wishbone write data.
  output logic [smx_pkg::DAT_W-1:0] wb_dat_r, // Wishbone read data.
  output logic wb_ack, // Wishbone acknowledge.
  input wire logic [NK-1:0] keying_src, // Keying source levels.
  input wire logic [NC-1:0] carrier_src, // Carrier source levels.
  output logic mixed_output_pin, // Modulated output pin.
  output logic pad_slew_limit, // High asks the pad to limit slew.
  output logic [NK-1:0] keying_source_pin_release, // Detach keying source from its pin.
  output logic [NC-1:0] upper_carrier_pin_release, // Detach upper carrier from its pin.
  output logic [NC-1:0] lower_carrier_pin_release // Detach lower carrier from its pin.
);
  import smx_pkg::*;

  typedef struct packed {
    logic ack;
    logic [DAT_W-1:0] rdat;
    logic [7:0] ctl;
    logic [7:0] key;
    logic [7:0] upc;
    logic [7:0] loc;
    logic mix;
    logic pin;
    logic slew;
    logic [NK-1:0] krel;
    logic [NC-1:0] urel;
    logic [NC-1:0] lrel;
  } smx_state_s;

  smx_state_s q;
  smx_state_s n;
  logic [1:0] rst_q;
  logic rst_n;
  logic [NK-1:0] key_s;
  logic [NC-1:0] car_s;
  logic [NK-1:0] key_hit;
  logic [NC-1:0] up_hit;
  logic [NC-1:0] lo_hit;
  logic [15:0] kx;
  logic [15:0] cx;
  logic [3:0] key_sel;
  logic key_val;
  logic up_val;
  logic lo_val;
  logic raw;
  logic mix_d;
  logic req;
  logic wr;
  logic [5:0] word;

  // Reset is released through two flip-flops; assertion is immediate.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Source levels may come from pins, so both groups are synchronised.
  smx_sync #(.W(NK)) u_key_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(keying_src),
    .q(key_s)
  );
  smx_sync #(.W(NC)) u_car_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(carrier_src),
    .q(car_s)
  );

  // Per-source release decode: a source is detached only while selected.
  for (genvar k = 0; k < NK; k++) begin : g_key
    assign key_hit[k] = q.key[SRC_REL] && (q.key[3:0] == SEL_W'(k + 1)); // [R4]
  end
  for (genvar k = 0; k < NC; k++) begin : g_car
    assign up_hit[k] = q.upc[SRC_REL] && (q.upc[3:0] == SEL_W'(k + 1)); // [R1]
    assign lo_hit[k] = q.loc[SRC_REL] && (q.loc[3:0] == SEL_W'(k + 1)); // [R2]
  end

  // Source selection; index zero is the software value or ground.
  always_comb begin
    kx = 16'({key_s, q.ctl[CTL_SOFT]}); // [R3]
    cx = 16'({car_s, 1'b0});
    key_sel = q.ctl[CTL_ON] ? q.key[3:0] : SEL_NONE; // [R14]
    key_val = kx[key_sel];
    up_val = q.ctl[CTL_ON] & (cx[q.upc[3:0]] ^ q.upc[CAR_POL]); // [R14]
    lo_val = q.ctl[CTL_ON] & (cx[q.loc[3:0]] ^ q.loc[CAR_POL]); // [R14]
    raw = (key_val & up_val) | (~key_val & lo_val); // [R13]
    mix_d = raw ^ q.ctl[CTL_INV]; // [R5]
  end

  // Bus decode helpers.
  assign req = wb_cyc && wb_stb && !q.ack;
  assign wr = req && wb_we && wb_sel[0];
  assign word = wb_adr[7:2];

  // Next state: bus slave, register writes and the output path.
  // No sleep input exists; mixing runs on every clock as it is. [R7] [R8]
  always_comb begin
    n = q;
    n.ack = req;
    n.rdat = '0;
    if (wr) begin
      unique case (word)
        OFS_CTL[7:2]: n.ctl = (q.ctl & ~CTL_WMASK) | (wb_dat_w[7:0] & CTL_WMASK); // [R12]
        OFS_KEY[7:2]: n.key = (q.key & ~KEY_WMASK) | (wb_dat_w[7:0] & KEY_WMASK);
        OFS_UPC[7:2]: n.upc = (q.upc & ~CAR_WMASK) | (wb_dat_w[7:0] & CAR_WMASK);
        OFS_LOC[7:2]: n.loc = (q.loc & ~CAR_WMASK) | (wb_dat_w[7:0] & CAR_WMASK);
        default: n.ctl = q.ctl;
      endcase
    end
    if (req && !wb_we) begin
      unique case (word)
        OFS_CTL[7:2]: n.rdat = DAT_W'({q.ctl[7:4], q.mix, 2'b00, q.ctl[0]}); // [R12]
        OFS_KEY[7:2]: n.rdat = DAT_W'(q.key);
        OFS_UPC[7:2]: n.rdat = DAT_W'(q.upc);
        OFS_LOC[7:2]: n.rdat = DAT_W'(q.loc);
        default: n.rdat = '0;
      endcase
    end
    n.mix = mix_d; // [R12]
    n.pin = q.ctl[CTL_OE] & mix_d; // [R11] [R15]
    n.slew = q.ctl[CTL_SLEW]; // [R6]
    n.krel = key_hit; // [R4]
    n.urel = up_hit; // [R1]
    n.lrel = lo_hit; // [R2]
  end

  // State register; every field takes its default under reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.ack <= 1'b0; // [R9]
      q.rdat <= '0;
      q.ctl <= CTL_RST; // [R6] [R9] [R11]
      q.key <= KEY_RST;
      q.upc <= CAR_RST;
      q.loc <= CAR_RST;
      q.mix <= 1'b0; // [R12]
      q.pin <= 1'b0;
      q.slew <= CTL_RST[CTL_SLEW]; // [R6]
      q.krel <= '0;
      q.urel <= '0;
      q.lrel <= '0;
    end else begin
      q <= n;
    end
  end

  // Every output comes straight from the state register.
  assign wb_ack = q.ack;
  assign wb_dat_r = q.rdat;
  assign mixed_output_pin = q.pin;
  assign pad_slew_limit = q.slew;
  assign keying_source_pin_release = q.krel;
  assign upper_carrier_pin_release = q.urel;
  assign lower_carrier_pin_release = q.lrel;

  // Checks run on the system clock and pause under reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A write to the control word, whatever its data byte.
  sequence s_ctl_wr;
    wr && (word == OFS_CTL[7:2]);
  endsequence

  // The control word update has landed one edge later.
  sequence s_ctl_landed;
    ##1 (q.ctl == ($past(wb_dat_w[7:0]) & CTL_WMASK));
  endsequence

  // A selected upper source with release set is detached.
  property p_up_rel;
    q.upc[SRC_REL] && (q.upc[3:0] == 4'h1) |=> upper_carrier_pin_release[0];
  endproperty
  a_up_rel: assert property (p_up_rel) else $error("upper release missing"); // [R1]

  // Without the lower release bit no lower source is detached.
  property p_lo_rel;
    !q.loc[SRC_REL] |=> (lower_carrier_pin_release == '0);
  endproperty
  a_lo_rel: assert property (p_lo_rel) else $error("lower release stray"); // [R2]

  // With the soft source chosen the keying level equals the soft bit.
  property p_soft;
    q.ctl[CTL_ON] && (q.key[3:0] == SEL_NONE) |-> (key_val == q.ctl[CTL_SOFT]);
  endproperty
  a_soft: assert property (p_soft) else $error("soft keying not used"); // [R3]

  // Without the keying release bit no keying source is detached.
  property p_key_rel;
    !q.key[SRC_REL] |=> (keying_source_pin_release == '0);
  endproperty
  a_key_rel: assert property (p_key_rel) else $error("keying release stray"); // [R4]

  // The status bit is the raw mix with the invert bit applied.
  property p_inv;
    1'b1 |=> (q.mix == ($past(raw) ^ $past(q.ctl[CTL_INV])));
  endproperty
  a_inv: assert property (p_inv) else $error("output polarity wrong"); // [R5]

  // Clearing the slew bit over the bus drops the pad request two edges on.
  property p_slew;
    s_ctl_wr and (!wb_dat_w[CTL_SLEW]) |=> ##1 !pad_slew_limit;
  endproperty
  a_slew: assert property (p_slew) else $error("slew limit not removed"); // [R6]

  // After reset release the control word holds its default.
  property p_rst;
    $rose(rst_n) |-> (q.ctl == CTL_RST) && !mixed_output_pin && pad_slew_limit;
  endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong"); // [R9]

  // A control write lands on the next edge with the status bit untouched.
  property p_ctl_wr;
    s_ctl_wr |-> s_ctl_landed ##0 (q.ctl[CTL_STAT] == 1'b0);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write lost"); // [R12]

  // With the drive on the pin follows the mix one edge later.
  property p_drive;
    q.ctl[CTL_OE] |=> (mixed_output_pin == $past(mix_d));
  endproperty
  a_drive: assert property (p_drive) else $error("pin not driven"); // [R11]

  // With the drive off the pin is low one edge later.
  property p_low;
    !q.ctl[CTL_OE] |=> !mixed_output_pin;
  endproperty
  a_low: assert property (p_low) else $error("pin not held low"); // [R15]

  // With the keying level high the upper carrier reaches the mix.
  property p_pick;
    key_val |-> (raw == up_val);
  endproperty
  a_pick: assert property (p_pick) else $error("upper carrier not chosen"); // [R13]

  // An upper carrier at index one passes through when enabled.
  property p_upper_src;
    q.ctl[CTL_ON] && (q.upc[3:0] == 4'h1) && !q.upc[CAR_POL] |-> (up_val == car_s[0]);
  endproperty
  a_upper_src: assert property (p_upper_src) else $error("upper carrier wrong"); // [R13]

  // When off, the raw mix is ground and the keying and upper selections are kept.
  property p_off;
    !q.ctl[CTL_ON] && !wr |-> (raw == 1'b0) ##1 $stable(q.key) && $stable(q.upc);
  endproperty
  a_off: assert property (p_off) else $error("disabled mixer active"); // [R14]

  // The acknowledge is a single pulse one edge after the request.
  property p_ack;
    req |=> wb_ack ##1 !wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge timing wrong");

  // A lower carrier at index three passes through when enabled.
  property p_lower_src;
    q.ctl[CTL_ON] && (q.loc[3:0] == 4'h3) && !q.loc[CAR_POL] |-> (lo_val == car_s[2]);
  endproperty
  a_lower_src: assert property (p_lower_src) else $error("lower carrier wrong"); // [R13]

  // With the keying level low the lower carrier reaches the mix.
  property p_pick_lo;
    !key_val |-> (raw == lo_val);
  endproperty
  a_pick_lo: assert property (p_pick_lo) else $error("lower carrier not chosen"); // [R13]

  // A selected lower source with its release bit set is detached.
  property p_lo_rel_on;
    q.loc[SRC_REL] && (q.loc[3:0] == 4'h3) |=> lower_carrier_pin_release[2];
  endproperty
  a_lo_rel_on: assert property (p_lo_rel_on) else $error("lower release missing"); // [R2]

  // Without the upper release bit no upper source is detached.
  property p_up_rel_off;
    !q.upc[SRC_REL] |=> (upper_carrier_pin_release == '0);
  endproperty
  a_up_rel_off: assert property (p_up_rel_off) else $error("upper release stray"); // [R1]

  // A selected keying source with its release bit set is detached.
  property p_key_rel_on;
    q.key[SRC_REL] && (q.key[3:0] == 4'h1) |=> keying_source_pin_release[0];
  endproperty
  a_key_rel_on: assert property (p_key_rel_on) else $error("keying release missing"); // [R4]

  // Setting the slew bit over the bus raises the pad request two edges on.
  property p_slew_set;
    s_ctl_wr and wb_dat_w[CTL_SLEW] |=> ##1 pad_slew_limit;
  endproperty
  a_slew_set: assert property (p_slew_set) else $error("slew limit not restored"); // [R6]

  // Right after reset release no source is detached and no acknowledge stands.
  property p_rst_rel;
    $rose(rst_n) |-> (keying_source_pin_release == '0) && (upper_carrier_pin_release == '0)
      && (lower_carrier_pin_release == '0) && !wb_ack;
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("reset outputs wrong"); // [R9]

  // When off, keying is the software bit and both carriers are ground.
  property p_off_src;
    !q.ctl[CTL_ON] |-> (key_val == q.ctl[CTL_SOFT]) && !up_val && !lo_val;
  endproperty
  a_off_src: assert property (p_off_src) else $error("disabled sources not forced"); // [R14]

  // Read data stays zero outside an acknowledge.
  property p_dat_idle;
    !wb_ack |-> (wb_dat_r == '0);
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
endmodule
`default_nettype wire

// >>> rtl/smx_pkg.sv
// Package of register offsets, field positions and reset values for the signal mixer.
`default_nettype none
package smx_pkg;
  // Bus geometry.
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  // Register byte offsets (one aligned word each).
  localparam logic [7:0] OFS_CTL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_UPC = 8'h08;
  localparam logic [7:0] OFS_LOC = 8'h0C;
  // Field positions in modulator_control.
  localparam int CTL_ON = 7;
  localparam int CTL_OE = 6;
  localparam int CTL_SLEW = 5;
  localparam int CTL_INV = 4;
  localparam int CTL_STAT = 3;
  localparam int CTL_SOFT = 0;
  // Field positions in the source and carrier control registers.
  localparam int SRC_REL = 7;
  localparam int CAR_POL = 6;
  localparam int CAR_SYNC = 5;
  localparam int SEL_W = 4;
  // Values after reset.
  localparam logic [7:0] CTL_RST = 8'h20;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [7:0] CAR_RST = 8'h00;
  // Writable bits; all others hold zero and read as zero, except control bit 3, which reads the status.
  localparam logic [7:0] CTL_WMASK = 8'hF1;
  localparam logic [7:0] KEY_WMASK = 8'h8F;
  localparam logic [7:0] CAR_WMASK = 8'hEF;
  // Source index zero: software value for keying, ground for carriers.
  localparam logic [3:0] SEL_NONE = 4'h0;
  // Clock cycles from a write strobe to the acknowledge.
  localparam int ACK_CYCLES = 1;
endpackage
`default_nettype wire

// >>> rtl/smx_sync.sv
// Two-stage synchroniser for a group of asynchronous source levels.
`default_nettype none
module smx_sync #(
  parameter int W = 1 // Number of levels carried.
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronised active-low reset.
  input wire logic [W-1:0] d, // Asynchronous levels.
  output logic [W-1:0] q // Levels safe to use in the clk domain.
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smx_sync_s;

  smx_sync_s st_q;
  smx_sync_s st_d;

  // The first stage feeds only the second stage.
  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule
`default_nettype wire

// >>> tb/smx_src_model.sv
// Behavioural model of the peripherals that feed keying and carrier levels.
`default_nettype none
module smx_src_model #(
  parameter int NK = 10, // Keying sources.
  parameter int NC = 7 // Carrier sources.
) (
  input wire logic clk, // System clock.
  input wire logic [NK-1:0] key_set, // Keying levels asked for.
  input wire logic [NC-1:0] car_set, // Carrier levels asked for.
  output logic [NK-1:0] keying_src, // Keying levels at the mixer.
  output logic [NC-1:0] carrier_src // Carrier levels at the mixer.
);
  timeunit 1ns;
  timeprecision 100ps;
  // Sources run on the system clock whatever the power state, so they never pause.
  always @(posedge clk) begin
    keying_src <= key_set;
    carrier_src <= car_set;
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking testbench for the signal mixer.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import smx_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack, mixed_output_pin, pad_slew_limit;
  logic [9:0] key_set = 10'h000;
  logic [6:0] car_set = 7'h00;
  logic [9:0] keying_src, keying_source_pin_release;
  logic [6:0] carrier_src, upper_carrier_pin_release, lower_carrier_pin_release;
  int mismatches = 0;
  int checked = 0;
  // Clock at 40 MHz.
  always #12.5 clk = ~clk;
  smx_mixer #(.NK(10), .NC(7)) uut (.clk(clk), .resetn(resetn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .keying_src(keying_src), .carrier_src(carrier_src),
    .mixed_output_pin(mixed_output_pin), .pad_slew_limit(pad_slew_limit),
    .keying_source_pin_release(keying_source_pin_release),
    .upper_carrier_pin_release(upper_carrier_pin_release),
    .lower_carrier_pin_release(lower_carrier_pin_release));
  smx_src_model #(.NK(10), .NC(7)) src (.clk(clk), .key_set(key_set), .car_set(car_set),
    .keying_src(keying_src), .carrier_src(carrier_src));
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Compares one value and reports a difference.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic Wishbone cycle; holds the request until ack, then idles a cycle.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
      output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= {24'h0, dat};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      mismatches++;
      close_out();
    end else begin
      @(posedge clk);
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] d;
    wb(1'b1, adr, dat, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 8'h00, d);
    chk(what, d, exp);
  endtask
  // Lets a change pass the synchroniser and output stage, then checks the pin.
  task automatic pinchk(input logic exp);
    repeat (5) @(posedge clk);
    chk("pin", {31'h0, mixed_output_pin}, {31'h0, exp});
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("ctl", OFS_CTL, 32'h20);
    rdc("key", OFS_KEY, 32'h0);
    rdc("upc", OFS_UPC, 32'h0);
    rdc("loc", OFS_LOC, 32'h0);
    rdc("hole", 8'h10, 32'h0);
    chk("slew", {31'h0, pad_slew_limit}, 32'h1);
    pinchk(1'b0);
    $display("test defaults done");
    // Firmware sets every source before it turns the pin drive on.
    wr(OFS_KEY, 8'h81);
    wr(OFS_UPC, 8'h81);
    wr(OFS_LOC, 8'h83);
    wr(OFS_CTL, 8'hC0);
    chk("krel", {22'h0, keying_source_pin_release}, 32'h1);
    chk("urel", {25'h0, upper_carrier_pin_release}, 32'h1);
    chk("lrel", {25'h0, lower_carrier_pin_release}, 32'h4);
    chk("slew", {31'h0, pad_slew_limit}, 32'h0);
    // Every keying and carrier combination, plain and then inverted.
    for (int i = 0; i < 16; i++) begin
      key_set <= {9'h0, i[2]};
      car_set <= {4'h0, i[0], 1'b0, i[1]};
      if (i == 8) begin
        wr(OFS_CTL, 8'hD0);
      end
      pinchk((i[2] ? i[1] : i[0]) ^ i[3]);
    end
    $display("test mixing done");
    // Drive off: pin low while the status still follows the mix.
    key_set <= 10'h000;
    car_set <= 7'h00;
    wr(OFS_CTL, 8'h90);
    pinchk(1'b0);
    rdc("ctl", OFS_CTL, 32'h98);
    wr(OFS_CTL, 8'h28);
    rdc("ctl", OFS_CTL, 32'h20);
    chk("slew", {31'h0, pad_slew_limit}, 32'h1);
    // Disabled: sources all high, yet carriers are grounded.
    key_set <= 10'h3FF;
    car_set <= 7'h7F;
    wr(OFS_CTL, 8'h41);
    pinchk(1'b0);
    rdc("key", OFS_KEY, 32'h81);
    rdc("upc", OFS_UPC, 32'h81);
    // Software value chooses the carrier.
    wr(OFS_KEY, 8'h00);
    wr(OFS_CTL, 8'hC1);
    pinchk(1'b1);
    car_set <= 7'h7B;
    wr(OFS_CTL, 8'hC0);
    pinchk(1'b0);
    chk("krel", {22'h0, keying_source_pin_release}, 32'h0);
    $display("test control done");
    // Reset in mid-run restores the defaults.
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    chk("pin", {31'h0, mixed_output_pin}, 32'h0);
    chk("slew", {31'h0, pad_slew_limit}, 32'h1);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("ctl", OFS_CTL, 32'h20);
    rdc("upc", OFS_UPC, 32'h0);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
